// ### hw/ued_pkg.sv
// Shared constants and types for the endpoint control block.
package ued_pkg;
   // Endpoint count and the bit where transmit fields start.
   localparam int NUM_EP = 3;
   localparam int TX_BASE = 16;
   localparam int ADDR_W = 12;

   // Register offsets.
   localparam logic [11:0] OFS_ROLE = 12'h1a8;
   localparam logic [11:0] OFS_ARM = 12'h1b0;
   localparam logic [11:0] OFS_FLUSH = 12'h1b4;
   localparam logic [11:0] OFS_READY = 12'h1b8;
   localparam logic [11:0] OFS_DONE = 12'h1bc;
   localparam logic [11:0] OFS_CTRL0 = 12'h1c0;
   localparam logic [11:0] OFS_CTRL_STEP = 12'h004;

   // Controller role codes and reset value.
   localparam logic [1:0] ROLE_IDLE = 2'h0;
   localparam logic [1:0] ROLE_DEVICE = 2'h2;
   localparam logic [1:0] ROLE_HOST = 2'h3;
   localparam logic [31:0] RESET_WORD = 32'h0000_0000;

   // Endpoint setup field positions.
   localparam int TX_EN = 23;
   localparam int TX_TR = 22;
   localparam int TX_TI = 21;
   localparam int TX_KIND = 18;
   localparam int TX_HALT = 16;
   localparam int RX_EN = 7;
   localparam int RX_TR = 6;
   localparam int RX_TI = 5;
   localparam int RX_KIND = 2;
   localparam int RX_HALT = 0;

   // Storable bits of the setup words and the fixed enables of zero.
   localparam logic [31:0] CTRL0_STORE = 32'h0001_0001;
   localparam logic [31:0] CTRLN_STORE = 32'h00af_00af;
   localparam logic [31:0] CTRL0_FIXED = 32'h0080_0080;

   // Endpoint kind codes.
   localparam logic [1:0] KIND_CTRL = 2'h0;
   localparam logic [1:0] KIND_ISO = 2'h1;
   localparam logic [1:0] KIND_BULK = 2'h2;
   localparam logic [1:0] KIND_INTR = 2'h3;

   // Timing counts in clock cycles.
   localparam int XFER_CYCLES = 8;
   localparam int ARM_DELAY_CYCLES = 4;
   localparam int ANSWER_LIMIT = 16;

   typedef enum logic [2:0] {
      TOK_OUT = 3'b001,
      TOK_IN = 3'b010,
      TOK_SETUP = 3'b100
   } ued_token_t;

   typedef enum logic [3:0] {
      HS_NONE = 4'b0001,
      HS_ACK = 4'b0010,
      HS_NAK = 4'b0100,
      HS_STALL = 4'b1000
   } ued_hs_t;

   // Mask of the endpoint bits in use in both halves.
   function automatic logic [31:0] ep_mask(input int n);
      logic [31:0] m;
      m = 32'h0000_0000;
      for (int i = 0; i < n; i++) begin
         m[i] = 1'b1;
         m[TX_BASE + i] = 1'b1;
      end
      return m;
   endfunction : ep_mask
endpackage : ued_pkg

// ### hw/ued_link_if.sv
// Transaction link between the host end and the device end.
`timescale 1ns/1ps
interface ued_link_if;
   logic tok_valid;
   ued_pkg::ued_token_t tok_kind;
   logic [1:0] tok_ep;
   logic tok_pid;
   logic hs_valid;
   ued_pkg::ued_hs_t hs_code;
   logic hs_pid;

   modport device (
      input tok_valid,
      input tok_kind,
      input tok_ep,
      input tok_pid,
      output hs_valid,
      output hs_code,
      output hs_pid
   );

   modport host (
      output tok_valid,
      output tok_kind,
      output tok_ep,
      output tok_pid,
      input hs_valid,
      input hs_code,
      input hs_pid
   );
endinterface : ued_link_if

// ### hw/ued_host.sv
// Host end: issues one token and collects the handshake.
`timescale 1ns/1ps
module ued_host #(
   parameter int LIMIT = ued_pkg::ANSWER_LIMIT
) (
   input wire logic clk,
   input wire logic rst,
   ued_link_if.host link,
   input wire logic start,
   input wire ued_pkg::ued_token_t start_kind,
   input wire logic [1:0] start_ep,
   input wire logic start_pid,
   output logic busy,
   output logic result_valid,
   output ued_pkg::ued_hs_t result_code,
   output logic result_pid
);
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_SEND = 3'b010,
      ST_WAIT = 3'b100
   } ued_hstate_t;

   ued_hstate_t state;
   logic [7:0] wait_cnt;

   if (LIMIT < ued_pkg::XFER_CYCLES + 2 || LIMIT > 255) begin : g_chk
      $error("answer limit out of range");
   end

   ////////////////////////////////////////////////////////////////////
   // Token sequencing; a new token is only offered once the previous
   // answer is in, so the device never sees overlapping requests.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state <= ST_IDLE;
         link.tok_valid <= 1'b0;
         link.tok_kind <= ued_pkg::TOK_OUT;
         link.tok_ep <= 2'h0;
         link.tok_pid <= 1'b0;
         wait_cnt <= 8'h00;
         result_valid <= 1'b0;
         result_code <= ued_pkg::HS_NONE;
         result_pid <= 1'b0;
      end else begin
         result_valid <= 1'b0;
         link.tok_valid <= 1'b0;
         case (state)
            ST_IDLE: begin
               if (start) begin
                  link.tok_valid <= 1'b1;
                  link.tok_kind <= start_kind;
                  link.tok_ep <= start_ep;
                  link.tok_pid <= start_pid;
                  state <= ST_SEND;
               end
            end
            ST_SEND: begin
               wait_cnt <= 8'h00;
               state <= ST_WAIT;
            end
            ST_WAIT: begin
               if (link.hs_valid) begin
                  result_valid <= 1'b1;
                  result_code <= link.hs_code;
                  result_pid <= link.hs_pid;
                  state <= ST_IDLE;
               end else if (wait_cnt == 8'(LIMIT)) begin
                  result_valid <= 1'b1;
                  result_code <= ued_pkg::HS_NONE;
                  result_pid <= 1'b0;
                  state <= ST_IDLE;
               end else begin
                  wait_cnt <= wait_cnt + 8'h01;
               end
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   // Busy covers the whole token to answer span.
   assign busy = (state != ST_IDLE);
endmodule : ued_host

// ### hw/ued_device.sv
// Device end: endpoint arm, flush, ready, done and setup registers.
//
// Function
// - Flush write discards primed endpoint buffers.
// - Packet in progress finishes before flushing.
// - Flush bits clear themselves when done.
// - Transmit bit 16+n, receive bit n.
// - Arm request sets buffer ready bit.
// - Ready appears cycles after arm, never same.
// - Bus reset, consumption, flush clear ready.
// - Retired buffer briefly drops ready bit.
// - IN sets transmit done; OUT/SETUP receive.
// - Done bit and interrupt pulse coincide.
// - Writing one clears done bit.
// - Endpoint zero fixed enabled control endpoint.
// - Zero halt stalls until cleared or SETUP.
// - SETUP sets or clears nonzero endpoint halt.
// - Toggle restart write resynchronises data PID.
// - Toggle ignore sends DATA0, accepts both.
// - Kind codes control, iso, bulk, interrupt.
// - Unused half should be set bulk.
// - Software writes data source bit zero.
// - Nonzero endpoints enabled by bits 23, 7.
// - Functions act only in device role; done and setup word writes act in any role.
// - Arm bit clears once priming succeeds.
// - Role field written once after reset.
`timescale 1ns/1ps
module ued_device #(
   parameter int NUM_EP = ued_pkg::NUM_EP,
   parameter int XFER = ued_pkg::XFER_CYCLES,
   parameter int ARM_DELAY = ued_pkg::ARM_DELAY_CYCLES
) (
   input wire logic clk,
   input wire logic rst,
   ued_link_if.device link,
   input wire logic [11:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   input wire logic usb_bus_reset,
   input wire logic [31:0] interrupt_on_finish_flag,
   output logic transfer_interrupt_status
);
   localparam logic [31:0] EP_MASK = ued_pkg::ep_mask(NUM_EP);

   if (NUM_EP < 1 || NUM_EP > 3 || XFER < 1 || XFER > 255 ||
       ARM_DELAY < 1 || ARM_DELAY > 255) begin : g_chk
      $error("device parameters out of range");
   end

   // Single-bit word at a given position.
   function automatic logic [31:0] one_hot(input logic [4:0] idx);
      logic [31:0] v;
      v = 32'h0000_0000;
      v[idx] = 1'b1;
      return v;
   endfunction : one_hot

   // Write strobe qualified by an offset.
   function automatic logic hit(input logic s, input logic [11:0] a,
                                input logic [11:0] o);
      return s && (a == o);
   endfunction : hit

   logic [1:0] role;
   logic role_locked;
   logic [31:0] arm;
   logic [31:0] flush;
   logic [31:0] ready;
   logic [31:0] done;
   logic [31:0] toggle;
   logic [31:0] ctrl [NUM_EP];
   logic [7:0] arm_cnt;
   logic busy;
   logic [7:0] xcnt;
   logic [4:0] cur_bit;
   logic cur_fin;
   logic cur_setup;
   logic cur_ign;
   logic cur_pid;
   ued_pkg::ued_hs_t cur_code;

   logic dev_mode;
   logic promote;
   logic fin_now;
   logic take;
   logic [31:0] in_prog;
   logic [31:0] can_flush;
   logic [31:0] wr_arm;
   logic [31:0] wr_flush;
   logic [31:0] wr_done;
   logic [31:0] fin_bit;

   logic tk_tx;
   logic tk_ok;
   logic [1:0] tk_ep;
   logic [4:0] tk_bit;
   logic tk_halt;
   logic tk_ign;
   logic tk_fin;
   ued_pkg::ued_hs_t tk_code;

   ////////////////////////////////////////////////////////////////////
   // device role gate.
   assign dev_mode = (role == ued_pkg::ROLE_DEVICE);
   assign take = dev_mode && link.tok_valid && !busy;
   assign fin_now = busy && (xcnt == 8'h00);
   assign fin_bit = (fin_now && cur_fin) ? one_hot(cur_bit) : '0;
   assign wr_arm = (dev_mode && hit(reg_wr, reg_addr, ued_pkg::OFS_ARM))
                   ? (reg_wdata & EP_MASK) : '0;
   assign wr_flush =
      (dev_mode && hit(reg_wr, reg_addr, ued_pkg::OFS_FLUSH))
      ? (reg_wdata & EP_MASK) : '0;
   assign wr_done = hit(reg_wr, reg_addr, ued_pkg::OFS_DONE)
                    ? (reg_wdata & EP_MASK) : '0;
   assign in_prog = (busy && cur_fin) ? one_hot(cur_bit) : '0;
   assign can_flush = flush & ~in_prog;
   assign promote = (arm != '0) && (arm_cnt == 8'(ARM_DELAY - 1));

   ////////////////////////////////////////////////////////////////////
   // write once role.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         role <= ued_pkg::ROLE_IDLE;
         role_locked <= 1'b0;
      end else if (hit(reg_wr, reg_addr, ued_pkg::OFS_ROLE) &&
                   !role_locked) begin
         role <= reg_wdata[1:0];
         role_locked <= 1'b1;
      end
   end

   // Arm delay counter; it runs while any arm bit is set and restarts
   // on promotion, so link traffic has no effect on the latency.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         arm_cnt <= 8'h00;
      end else if (arm == '0 || promote) begin
         arm_cnt <= 8'h00;
      end else begin
         arm_cnt <= arm_cnt + 8'h01;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         arm <= ued_pkg::RESET_WORD;
      end else if (usb_bus_reset) begin
         arm <= ued_pkg::RESET_WORD;
      end else begin
         arm <= (arm & ~(promote ? arm : '0) & ~can_flush) | wr_arm;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         flush <= ued_pkg::RESET_WORD;
      end else if (usb_bus_reset) begin
         flush <= ued_pkg::RESET_WORD;
      end else begin
         flush <= (flush & ~can_flush) | wr_flush;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ready <= ued_pkg::RESET_WORD;
      end else if (usb_bus_reset) begin
         ready <= ued_pkg::RESET_WORD;
      end else begin
         ready <= (ready & ~can_flush & ~fin_bit) |
                  (promote ? (arm & ~can_flush) : '0);
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         done <= ued_pkg::RESET_WORD;
         transfer_interrupt_status <= 1'b0;
      end else begin
         done <= (done & ~wr_done) | fin_bit;
         transfer_interrupt_status <=
            ((fin_bit & interrupt_on_finish_flag) != '0);
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Token decode; enable, halt, readiness and toggle in that order.
   always_comb begin
      tk_tx = (link.tok_kind == ued_pkg::TOK_IN);
      tk_ok = (32'(link.tok_ep) < 32'(NUM_EP));
      tk_ep = tk_ok ? link.tok_ep : 2'h0;
      tk_bit = tk_tx ? 5'(ued_pkg::TX_BASE + 32'(tk_ep)) : {3'h0, tk_ep};
      tk_halt = ctrl[tk_ep][tk_tx ? ued_pkg::TX_HALT : ued_pkg::RX_HALT];
      tk_ign = ctrl[tk_ep][tk_tx ? ued_pkg::TX_TI : ued_pkg::RX_TI];
      tk_fin = 1'b0;
      tk_code = ued_pkg::HS_NONE;
      if (!tk_ok || (tk_ep != 2'h0 &&
          !ctrl[tk_ep][tk_tx ? ued_pkg::TX_EN : ued_pkg::RX_EN])) begin
         tk_code = ued_pkg::HS_NONE;
      end else if (link.tok_kind == ued_pkg::TOK_SETUP) begin
         tk_code = ued_pkg::HS_ACK;
         tk_fin = 1'b1;
      end else if (tk_halt) begin
         tk_code = ued_pkg::HS_STALL;
      end else if (!ready[tk_bit]) begin
         tk_code = ued_pkg::HS_NAK;
      end else begin
         tk_code = ued_pkg::HS_ACK;
         tk_fin = tk_tx || tk_ign || (link.tok_pid == toggle[tk_bit]);
      end
   end

   // Transaction timer; a taken token holds the endpoint for XFER
   // cycles, which is the span a flush must wait out.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         busy <= 1'b0;
         xcnt <= 8'h00;
         cur_bit <= 5'h00;
         cur_fin <= 1'b0;
         cur_setup <= 1'b0;
         cur_ign <= 1'b0;
         cur_pid <= 1'b0;
         cur_code <= ued_pkg::HS_NONE;
         link.hs_valid <= 1'b0;
         link.hs_code <= ued_pkg::HS_NONE;
         link.hs_pid <= 1'b0;
      end else begin
         link.hs_valid <= fin_now;
         if (fin_now) begin
            link.hs_code <= cur_code;
            link.hs_pid <= cur_pid;
         end
         if (take) begin
            busy <= 1'b1;
            xcnt <= 8'(XFER - 1);
            cur_bit <= tk_bit;
            cur_fin <= tk_fin;
            cur_setup <= (link.tok_kind == ued_pkg::TOK_SETUP);
            cur_ign <= tk_ign;
            cur_pid <= tk_tx ? !tk_ign && toggle[tk_bit] : cur_pid;
            cur_code <= tk_code;
         end else if (fin_now) begin
            busy <= 1'b0;
         end else if (busy) begin
            xcnt <= xcnt - 8'h01;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Data toggles; a finished SETUP leaves both halves expecting DATA1.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         toggle <= ued_pkg::RESET_WORD;
      end else if (usb_bus_reset) begin
         toggle <= ued_pkg::RESET_WORD;
      end else begin
         for (int e = 0; e < NUM_EP; e++) begin
            if (e != 0 && hit(reg_wr, reg_addr, 12'(ued_pkg::OFS_CTRL0 +
                e * ued_pkg::OFS_CTRL_STEP))) begin
               if (reg_wdata[ued_pkg::TX_TR]) begin
                  toggle[ued_pkg::TX_BASE + e] <= 1'b0;
               end
               if (reg_wdata[ued_pkg::RX_TR]) begin
                  toggle[e] <= 1'b0;
               end
            end
         end
         if (fin_now && cur_fin && cur_setup) begin
            toggle[cur_bit] <= 1'b1;
            toggle[5'(ued_pkg::TX_BASE) + cur_bit] <= 1'b1;
         end else if (fin_now && cur_fin && !cur_ign) begin
            toggle[cur_bit] <= ~toggle[cur_bit];
         end
      end
   end

   // Setup words; a SETUP's halt update overrides a same-cycle write.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         for (int e = 0; e < NUM_EP; e++) begin
            ctrl[e] <= ued_pkg::RESET_WORD;
         end
      end else begin
         for (int e = 0; e < NUM_EP; e++) begin
            if (hit(reg_wr, reg_addr, 12'(ued_pkg::OFS_CTRL0 +
                e * ued_pkg::OFS_CTRL_STEP))) begin
               ctrl[e] <= reg_wdata & ((e == 0) ? ued_pkg::CTRL0_STORE
                                                : ued_pkg::CTRLN_STORE);
            end
            if (take && link.tok_kind == ued_pkg::TOK_SETUP &&
                tk_code == ued_pkg::HS_ACK && 32'(tk_ep) == e) begin
               ctrl[e][ued_pkg::TX_HALT] <= (e != 0) &&
                  (ctrl[e][ued_pkg::TX_KIND +: 2] != ued_pkg::KIND_CTRL);
               ctrl[e][ued_pkg::RX_HALT] <= (e != 0) &&
                  (ctrl[e][ued_pkg::RX_KIND +: 2] != ued_pkg::KIND_CTRL);
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // reserved read zero.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         reg_rdata <= ued_pkg::RESET_WORD;
      end else if (reg_rd) begin
         reg_rdata <= ued_pkg::RESET_WORD;
         if (reg_addr == ued_pkg::OFS_ROLE) begin
            reg_rdata <= {30'h0000_0000, role};
         end else if (reg_addr == ued_pkg::OFS_ARM) begin
            reg_rdata <= arm;
         end else if (reg_addr == ued_pkg::OFS_FLUSH) begin
            reg_rdata <= flush;
         end else if (reg_addr == ued_pkg::OFS_READY) begin
            reg_rdata <= ready;
         end else if (reg_addr == ued_pkg::OFS_DONE) begin
            reg_rdata <= done;
         end else begin
            for (int e = 0; e < NUM_EP; e++) begin
               if (reg_addr == 12'(ued_pkg::OFS_CTRL0 +
                   e * ued_pkg::OFS_CTRL_STEP)) begin
                  reg_rdata <= (e == 0) ? (ctrl[e] | ued_pkg::CTRL0_FIXED)
                                        : ctrl[e];
               end
            end
         end
      end
   end
endmodule : ued_device

// ### test/ued_link_chk.sv
// Checker for the token and handshake link between the two ends.
`timescale 1ns/1ps
module ued_link_chk #(
   parameter int XFER = ued_pkg::XFER_CYCLES
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic tok_valid,
   input wire ued_pkg::ued_token_t tok_kind,
   input wire logic [1:0] tok_ep,
   input wire logic tok_pid,
   input wire logic hs_valid,
   input wire ued_pkg::ued_hs_t hs_code,
   input wire logic hs_pid
);
   // Every answer comes a fixed time after its token.
   localparam int ANS = XFER + 1;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   ////////////////////////////////////////////////////////////////////////
   // Token shapes and the quiet time after a token.
   sequence s_setup;
      tok_valid && tok_kind == ued_pkg::TOK_SETUP;
   endsequence

   sequence s_quiet;
      !hs_valid [*8];
   endsequence

   ////////////////////////////////////////////////////////////////////////
   // Timing of answers, and the spacing of tokens.
   property p_answer_cause;
      hs_valid |-> $past(tok_valid, ANS);
   endproperty
   a_answer_cause: assert property (p_answer_cause)
      else $error("Handshake without a matching token.");

   property p_not_early;
      tok_valid |=> s_quiet;
   endproperty
   a_not_early: assert property (p_not_early)
      else $error("Handshake came too early.");

   property p_one_token;
      tok_valid |=> !tok_valid [*8];
   endproperty
   a_one_token: assert property (p_one_token)
      else $error("Second token while a packet runs.");

   ////////////////////////////////////////////////////////////////////////
   // Handshake codes tied to the token that caused them and held between answers.
   property p_setup_ack;
      s_setup |-> ##ANS (!hs_valid || hs_code inside
         {ued_pkg::HS_ACK, ued_pkg::HS_NONE});
   endproperty
   a_setup_ack: assert property (p_setup_ack)
      else $error("SETUP was refused.");

   property p_ep0_alive;
      tok_valid && tok_ep == 2'h0 |->
         ##ANS (!hs_valid || hs_code != ued_pkg::HS_NONE);
   endproperty
   a_ep0_alive: assert property (p_ep0_alive)
      else $error("Endpoint zero answered as disabled.");

   property p_range;
      tok_valid && tok_ep == 2'h3 |->
         ##ANS (!hs_valid || hs_code == ued_pkg::HS_NONE);
   endproperty
   a_range: assert property (p_range)
      else $error("Unmapped endpoint answered.");

   property p_hold;
      !hs_valid |-> $stable(hs_code) && $stable(hs_pid);
   endproperty
   a_hold: assert property (p_hold)
      else $error("Handshake changed between answers.");

   property p_pid_in;
      hs_valid && $changed(hs_pid) |->
         $past(tok_kind, ANS) == ued_pkg::TOK_IN;
   endproperty
   a_pid_in: assert property (p_pid_in)
      else $error("Data PID changed on a non-IN answer.");
endmodule : ued_link_chk

// ### test/usb_device_endpoint_control_tb.sv
// Self-checking bench joining the host and device ends.
`timescale 1ns/1ps
module usb_device_endpoint_control_tb;
   localparam int XFER = ued_pkg::XFER_CYCLES;
   localparam logic [11:0] C0 = ued_pkg::OFS_CTRL0;
   localparam logic [11:0] C1 = C0 + ued_pkg::OFS_CTRL_STEP;
   localparam logic [11:0] C2 = C1 + ued_pkg::OFS_CTRL_STEP;
   logic clk, rst, reg_wr, reg_rd, usb_bus_reset, irq;
   logic [11:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata, got;
   logic start, busy, result_valid, result_pid, got_pid;
   logic [1:0] start_ep;
   ued_pkg::ued_token_t start_kind;
   ued_pkg::ued_hs_t result_code;
   int err_total, n_compared, n_irq, cycles;

   ued_link_if i_ued_link_if();

   ued_device #(.NUM_EP(ued_pkg::NUM_EP), .XFER(XFER),
      .ARM_DELAY(ued_pkg::ARM_DELAY_CYCLES)) i_ued_device (
      .clk(clk), .rst(rst), .link(i_ued_link_if), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .usb_bus_reset(usb_bus_reset),
      .interrupt_on_finish_flag(32'h0002_0000),
      .transfer_interrupt_status(irq));

   ued_host #(.LIMIT(ued_pkg::ANSWER_LIMIT)) i_ued_host (
      .clk(clk), .rst(rst), .link(i_ued_link_if), .start(start),
      .start_kind(start_kind), .start_ep(start_ep), .start_pid(1'h0),
      .busy(busy), .result_valid(result_valid),
      .result_code(result_code), .result_pid(result_pid));

   ued_link_chk #(.XFER(XFER)) i_ued_link_chk (
      .clk(clk), .rst(rst), .tok_valid(i_ued_link_if.tok_valid),
      .tok_kind(i_ued_link_if.tok_kind), .tok_ep(i_ued_link_if.tok_ep),
      .tok_pid(i_ued_link_if.tok_pid), .hs_valid(i_ued_link_if.hs_valid),
      .hs_code(i_ued_link_if.hs_code), .hs_pid(i_ued_link_if.hs_pid));

   ////////////////////////////////////////////////////////////////////////
   // Verdict and end of run; also reached when the watchdog fires.
   task results;
      if (err_total == 0 && n_compared > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : results

   // Comparison shared by all scenarios.
   task chk(input logic [31:0] g, input logic [31:0] e);
      n_compared++;
      if (g !== e) begin
         err_total++;
         $display("Error at %0t: got %h expected %h", $time, g, e);
      end
   endtask : chk

   // Register bus: one-cycle strobes, read data in the next cycle.
   task wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_wr <= 1'h1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'h0;
   endtask : wr

   task rd(input logic [11:0] a);
      @(posedge clk);
      reg_rd <= 1'h1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'h0;
      #1 got = reg_rdata;
   endtask : rd

   task rdc(input logic [11:0] a, input logic [31:0] e);
      rd(a);
      chk(got, e);
   endtask : rdc

   // Ready latency varies, so poll under a bound as software would.
   task poll(input logic [31:0] m);
      for (int i = 0; i < 20; i++) begin
         rd(ued_pkg::OFS_READY);
         if ((got & m) === m) break;
      end
      chk(got & m, m);
   endtask : poll

   // One token; a flush word is written while the packet runs.
   task xfer(input ued_pkg::ued_token_t k, input logic [1:0] e,
      input ued_pkg::ued_hs_t x, input logic [31:0] fl);
      @(posedge clk);
      start <= 1'h1;
      start_kind <= k;
      start_ep <= e;
      @(posedge clk);
      start <= 1'h0;
      wr(ued_pkg::OFS_FLUSH, fl);
      for (int i = 0; i < 40; i++) begin
         @(posedge clk);
         #1;
         if (result_valid === 1'h1) break;
      end
      got_pid = result_pid;
      chk({28'h000_0000, result_code}, {28'h000_0000, x});
      chk({31'h0000_0000, busy}, 32'h0000_0000);
   endtask : xfer

   // Arm a transmit buffer, send it and check the data PID used.
   task send(input logic [1:0] e, input logic p);
      wr(ued_pkg::OFS_ARM, 32'h0001_0000 << e);
      poll(32'h0001_0000 << e);
      xfer(ued_pkg::TOK_IN, e, ued_pkg::HS_ACK, 32'h0000_0000);
      chk({31'h0000_0000, got_pid}, {31'h0000_0000, p});
   endtask : send

   ////////////////////////////////////////////////////////////////////////
   // Before the device role is chosen nothing but registers works.
   task t_idle;
      rdc(12'h000, 32'h0000_0000);
      xfer(ued_pkg::TOK_IN, 2'h0, ued_pkg::HS_NONE, 32'h0000_0000);
      wr(ued_pkg::OFS_ARM, 32'h0001_0001);
      repeat (8) @(posedge clk);
      rdc(ued_pkg::OFS_READY, 32'h0000_0000);
      wr(ued_pkg::OFS_ROLE, {30'h0000_0000, ued_pkg::ROLE_DEVICE});
      wr(ued_pkg::OFS_ROLE, {30'h0000_0000, ued_pkg::ROLE_HOST});
      rdc(ued_pkg::OFS_ROLE, 32'h0000_0002);
   endtask : t_idle

   // Endpoint zero: fixed fields, halt until SETUP, done events.
   task t_zero;
      wr(C0, 32'hffff_ffff);
      rdc(C0, 32'h0081_0081);
      wr(C0, 32'h0001_0000);
      xfer(ued_pkg::TOK_IN, 2'h0, ued_pkg::HS_STALL, 32'h0000_0000);
      xfer(ued_pkg::TOK_SETUP, 2'h0, ued_pkg::HS_ACK, 32'h0000_0000);
      rdc(C0, 32'h0080_0080);
      rdc(ued_pkg::OFS_DONE, 32'h0000_0001);
      xfer(ued_pkg::TOK_OUT, 2'h0, ued_pkg::HS_NAK, 32'h0000_0000);
      wr(ued_pkg::OFS_DONE, 32'h0000_0000);
      rdc(ued_pkg::OFS_DONE, 32'h0000_0001);
      wr(ued_pkg::OFS_DONE, 32'h0000_0001);
      rdc(ued_pkg::OFS_DONE, 32'h0000_0000);
   endtask : t_zero

   // Endpoint one: kinds, SETUP halts, arming, toggles, enable.
   task t_ep1;
      logic [31:0] w;
      for (int k = 0; k < 4; k++) begin
         w = 32'h0080_0080 | (32'(k) << 18) | (32'(k) << 2);
         wr(C1, w);
         rdc(C1, w);
      end
      wr(C1, 32'h0088_0080);
      xfer(ued_pkg::TOK_SETUP, 2'h1, ued_pkg::HS_ACK, 32'h0000_0000);
      rdc(C1, 32'h0089_0080);
      wr(C1, 32'h0088_0080);
      wr(ued_pkg::OFS_ARM, 32'h0002_0000);
      rdc(ued_pkg::OFS_READY, 32'h0000_0000);
      poll(32'h0002_0000);
      rdc(ued_pkg::OFS_ARM, 32'h0000_0000);
      xfer(ued_pkg::TOK_IN, 2'h1, ued_pkg::HS_ACK, 32'h0000_0000);
      chk({31'h0000_0000, got_pid}, 32'h0000_0001);
      rdc(ued_pkg::OFS_READY, 32'h0000_0000);
      rdc(ued_pkg::OFS_DONE, 32'h0002_0002);
      chk(32'(n_irq), 32'h0000_0001);
      xfer(ued_pkg::TOK_IN, 2'h1, ued_pkg::HS_NAK, 32'h0000_0000);
      send(2'h1, 1'h0);
      wr(C1, 32'h00c8_0080);
      send(2'h1, 1'h0);
      wr(C1, 32'h00a8_0080);
      send(2'h1, 1'h0);
      wr(C1, 32'h0008_0080);
      xfer(ued_pkg::TOK_IN, 2'h1, ued_pkg::HS_NONE, 32'h0000_0000);
      xfer(ued_pkg::TOK_IN, 2'h3, ued_pkg::HS_NONE, 32'h0000_0000);
   endtask : t_ep1

   // Flush idle and mid-packet, then a bus reset with a primed buffer ready.
   task t_flush;
      wr(C2, 32'h0088_0088);
      wr(ued_pkg::OFS_ARM, 32'h0004_0004);
      poll(32'h0004_0004);
      wr(ued_pkg::OFS_FLUSH, 32'h0000_0004);
      repeat (2) @(posedge clk);
      rdc(ued_pkg::OFS_READY, 32'h0004_0000);
      rdc(ued_pkg::OFS_FLUSH, 32'h0000_0000);
      xfer(ued_pkg::TOK_IN, 2'h2, ued_pkg::HS_ACK, 32'h0004_0000);
      rdc(ued_pkg::OFS_FLUSH, 32'h0000_0000);
      rdc(ued_pkg::OFS_READY, 32'h0000_0000);
      wr(ued_pkg::OFS_ARM, 32'h0001_0000);
      poll(32'h0001_0000);
      @(posedge clk);
      usb_bus_reset <= 1'h1;
      @(posedge clk);
      usb_bus_reset <= 1'h0;
      rdc(ued_pkg::OFS_READY, 32'h0000_0000);
   endtask : t_flush

   ////////////////////////////////////////////////////////////////////////
   // Clock at 40 MHz.
   initial begin
      clk = 1'h0;
      forever #12.5 clk = ~clk;
   end

   // Interrupt pulses and a watchdog on the whole run.
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (irq === 1'h1) n_irq <= n_irq + 1;
      if (cycles == 20000) begin
         err_total++;
         results();
      end
   end

   // Main sequence: reset for 20 cycles, then each scenario in turn.
   initial begin
      {rst, reg_wr, reg_rd, usb_bus_reset, start} = 5'h10;
      reg_addr = 12'h000;
      reg_wdata = 32'h0000_0000;
      start_kind = ued_pkg::TOK_OUT;
      start_ep = 2'h0;
      {err_total, n_compared, n_irq, cycles} = '0;
      repeat (20) @(posedge clk);
      rst <= 1'h0;
      t_idle();
      t_zero();
      t_ep1();
      t_flush();
      results();
   end
endmodule : usb_device_endpoint_control_tb
